// >>> char_oled_command_decoder_bench.sv
/*
  Self-checking bench for the command decoder.
  Assumes the host model drives APB; expectations come from the rules.
*/
`timescale 1ns/1ns
`define CHK(nm, ex, got) begin checks_done++; if ((got) !== (ex)) begin \
  err_count++; $display("mismatch %s exp %h got %h", nm, ex, got); end end
module char_oled_command_decoder_bench;
  logic        pclk;      // Core clock
  logic        presetn;   // Async reset, active low
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        gpio_out;
  logic        gpio_oe;
  logic        regulator_en;
  logic [31:0] q;         // Last read word
  logic        e;         // Last error response
  int          err_count;
  int          checks_done;

  cocd_decoder i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .gpio_out(gpio_out), .gpio_oe(gpio_oe), .regulator_en(regulator_en));
  cocd_host i_host (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
    .prdata(prdata), .pslverr(pslverr));

  // 40 ns clock
  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  // Bus shorthands: command, data, read
  task automatic wc(input logic [7:0] b);
    i_host.xfer(1'b1, cocd_pkg::OFS_CMD, {24'h0, b}, q, e);
  endtask
  task automatic wd(input logic [7:0] b);
    i_host.xfer(1'b1, cocd_pkg::OFS_DATA, {24'h0, b}, q, e);
  endtask
  task automatic rd(input logic [7:0] a);
    i_host.xfer(1'b0, a, 32'h0, q, e);
  endtask

  // Reset state of mode and option fields
  task automatic t_reset();
    rd(cocd_pkg::OFS_CFG0);
    `CHK("cfg0", 32'h0000_1606, q)
    rd(cocd_pkg::OFS_CFG1);
    `CHK("cfg1", 32'h0004_085C, q & 32'h3F0F_FCFF)
    `CHK("reg_en", 1'b1, regulator_en)
    `CHK("gpio", 2'b10, {gpio_oe, gpio_out})
    $display("t_reset done");
  endtask

  // Display control and function set
  task automatic t_basic();
    wc(8'h0F);
    wc(8'h2B);
    rd(cocd_pkg::OFS_CFG0);
    `CHK("disp", 3'b111, q[15:13])
    `CHK("width", 1'b0, q[10])
    `CHK("lines_br", 3'b111, q[9:7])
    $display("t_basic done");
  endtask

  // Address loads, status pair, stepping
  task automatic t_addr();
    wc(8'hC5);
    rd(cocd_pkg::OFS_CMD);
    `CHK("ac", 8'h45, q[7:0])
    rd(cocd_pkg::OFS_CMD);
    `CHK("id", 8'h2A, q[7:0])
    wd(8'h41);
    rd(cocd_pkg::OFS_CMD);
    `CHK("ac_inc", 8'h46, q[7:0])
    wc(8'h04);
    wd(8'h42);
    rd(cocd_pkg::OFS_CMD);
    `CHK("ac_dec", 8'h45, q[7:0])
    wc(8'h45);
    rd(cocd_pkg::OFS_CMD);
    `CHK("cg_ac", 8'h05, q[7:0])
    wd(8'h1F);
    wc(8'h45);
    rd(cocd_pkg::OFS_DATA);
    `CHK("pat_ram", 8'h1F, q[7:0])
    $display("t_addr done");
  endtask

  // Clear display: counter zero, text filled with spaces
  task automatic t_clear();
    wc(8'h07);
    wc(8'hC5);
    wd(8'h55);
    rd(cocd_pkg::OFS_CFG0);
    `CHK("shift", 7'h01, q[22:16])
    wc(cocd_pkg::CMD_CLEAR);
    rd(cocd_pkg::OFS_CMD);
    `CHK("clr_ac", 7'h00, q[6:0])
    `CHK("busy", 1'b1, q[7])
    wc(8'hC5);
    rd(cocd_pkg::OFS_DATA);
    `CHK("clr_ram", 8'h20, q[7:0])
    wc(8'h02);
    rd(cocd_pkg::OFS_CMD);
    `CHK("home", 8'h00, q[7:0])
    rd(cocd_pkg::OFS_CFG0);
    `CHK("unshift", 7'h00, q[22:16])
    $display("t_clear done");
  endtask

  // Extended page, option commands and their parameters
  task automatic t_ext();
    wc(8'h27);
    wc(8'h26);
    wc(8'h04);
    rd(cocd_pkg::OFS_CFG0);
    `CHK("ext", 4'b1010, q[6:3])
    `CHK("dirs", 2'b00, q[2:1])
    // Selections A and B and scroll need the display command set off
    wc(cocd_pkg::CMD_FSEL_A);
    wc(8'h00);
    // Pin drivers follow the setting one cycle later
    repeat (2) @(posedge pclk);
    `CHK("reg_off", 1'b0, regulator_en)
    wc(cocd_pkg::CMD_FSEL_B);
    wc(8'h06);
    wc(8'h85);
    wc(8'hB5);
    wc(cocd_pkg::CMD_SD_ON);
    rd(cocd_pkg::OFS_CFG0);
    `CHK("sd_on", 1'b1, q[5])
    wc(cocd_pkg::CMD_GPIO);
    wc(8'h03);
    repeat (2) @(posedge pclk);
    `CHK("gpio_hi", 2'b11, {gpio_oe, gpio_out})
    wc(cocd_pkg::CMD_GPIO);
    wc(8'h00);
    repeat (2) @(posedge pclk);
    `CHK("gpio_z", 1'b0, gpio_oe)
    wc(cocd_pkg::CMD_CLKDIV);
    wc(8'h7A);
    rd(cocd_pkg::OFS_CFG1);
    `CHK("osc_div", 8'h7A, q[19:12])
    `CHK("split", 4'b1001, q[23:20])
    `CHK("scroll", 6'h05, q[29:24])
    $display("t_ext done");
  endtask

  // Lock lets only the command-set enable through
  task automatic t_lock();
    wc(cocd_pkg::CMD_SD_OFF);
    i_host.xfer(1'b1, cocd_pkg::OFS_CTRL, 32'h1, q, e);
    wc(cocd_pkg::CMD_SD_ON);
    wc(cocd_pkg::CMD_SD_OFF);
    rd(cocd_pkg::OFS_CFG0);
    `CHK("lock", 1'b1, q[5])
    i_host.xfer(1'b1, cocd_pkg::OFS_CTRL, 32'h0, q, e);
    rd(8'h40);
    `CHK("unmapped", 1'b1, e)
    $display("t_lock done");
  endtask

  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    err_count   = 0;
    checks_done = 0;
    presetn     = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_basic();
    t_addr();
    t_clear();
    t_ext();
    t_lock();
    close_out();
  end

  // Watchdog well beyond the expected few hundred cycles
  initial begin
    #(40 * 20000);
    err_count++;
    close_out();
  end
endmodule

// >>> cocd_decoder.sv
/*
  Command decoder of a character display controller, reached over APB.
  Writes to CMD are command bytes, writes to DATA are data bytes; reads of
  CMD are status reads and reads of DATA return display memory contents.
  Assumes a single APB master on pclk; all inputs synchronous to pclk.
*/
// Chosen here: the placing of the registers and register access over APB.
// Summary of operation
// R1: Clear fills text RAM with spaces, address zero
// R2: Return home zeroes address, undoes shift
// R3: Entry bit 1 picks increment or decrement
// R4: Entry bit 0 shifts display per access
// R5: Extended entry sets common and segment direction
// R6: Display control sets display, cursor, blink
// R7: Function set bit 4 picks bus width
// R8: Function set bit 3 picks line count
// R9: Function set bits 1:0 pick brightness
// R10: Function set bit 2 writes extension page bit
// R11: Extended function set: pattern blink, reverse
// R12: Top bits 01 load pattern RAM address
// R13: Bit 7 loads text RAM address
// R14: Extended bit 7 loads dot scroll quantity
// R15: Status read: busy, then address, then identifier
// R16: Data writes store, data reads return RAM
// R17: Command 71 parameter sets core regulator
// R18: Command 72 parameter sets split and ROM
// R19: Commands 78/79 clear or set command set bit
// R20: Locked interface accepts only command set enable; a parameter byte already awaited when the lock is set is still taken
// R21: Command D5 parameter sets divider, oscillator
// R22: Command DC parameter configures general pin
// R23: Host selects command or data by port
// R24: Undefined commands leave all state unchanged; the command write still resets the status read to return the address next
`timescale 1ns/1ns
module cocd_decoder #(
  parameter logic [6:0] PART_ID = 7'h2A // Arbitrary identifier value
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  output logic             gpio_out,
  output logic             gpio_oe,
  output logic             regulator_en
);

  // Address step for a RAM access, wrapping in the active memory
  function automatic logic [6:0] ac_step(input logic [6:0] ac,
                                         input logic inc, input logic cg);
    logic [6:0] n;
    n = inc ? ac + 7'h01 : ac - 7'h01;
    return cg ? {1'b0, n[5:0]} : n;
  endfunction

  // Mode and display state
  logic       re_q, sd_q;            // Page bits
  logic       inc_q, shift_en_q;     // Entry mode
  logic       com_dir_q, seg_dir_q;  // Scan directions
  logic       disp_q, cur_q, blk_q;  // On/off control
  logic       dl_q, lines_q;         // Bus width, line count
  logic [1:0] br_q;                  // Brightness ratio
  logic       be_q, rev_q;           // Pattern blink, reverse
  logic [5:0] sq_q;                  // Dot scroll quantity
  logic [6:0] shift_q;               // Net display shift
  logic [6:0] ac_q;                  // Address counter
  logic       ac_cg_q;               // Counter points into pattern RAM
  logic [7:0] reg_q;                 // Regulator setting byte
  logic [1:0] split_q, rom_q;        // Character split, ROM choice
  logic [3:0] osc_q, div_q;          // Clock settings
  logic [1:0] gpio_q;                // General pin mode
  logic       lock_q;                // Interface lock
  logic       stat_id_q;             // Next status read returns identifier
  logic       busy_q;                // Clear sweep in progress
  logic [6:0] clr_q;                 // Clear sweep index
  cocd_pkg::cocd_pend_t pend_q;      // Parameter byte awaited

  // Display memories
  logic [7:0] text_ram [cocd_pkg::TEXT_WORDS];
  logic [7:0] pat_ram  [cocd_pkg::PAT_WORDS];

  // Bus decode
  logic       acc, done, wr, rd, hit_cmd, hit_data, stall, mapped;
  logic [7:0] wb;
  logic       cmd_ok, lock_ok;

  assign acc      = psel && penable;
  assign done     = acc && pready;               // Completing edge
  assign wr       = done && pwrite;
  assign rd       = done && !pwrite;
  assign wb       = pwdata[7:0];
  assign hit_cmd  = (paddr == cocd_pkg::OFS_CMD);
  assign hit_data = (paddr == cocd_pkg::OFS_DATA);
  assign mapped   = hit_cmd || hit_data || paddr == cocd_pkg::OFS_CFG0
                 || paddr == cocd_pkg::OFS_CFG1
                 || paddr == cocd_pkg::OFS_CTRL;
  // Memory traffic waits for the clear sweep; status reads never wait
  assign stall    = busy_q && (hit_data || (hit_cmd && pwrite));

  // Command write with no parameter pending; lock admits only SD set
  assign lock_ok  = !lock_q || (re_q && wb == cocd_pkg::CMD_SD_ON); // [R20]
  assign cmd_ok   = wr && hit_cmd && pend_q == cocd_pkg::COCD_PEND_NONE
                 && lock_ok;

  // Ready: one wait cycle per transfer, longer for data accesses and command writes while clearing
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= acc && !pready && !stall;
      pslverr <= acc && !pready && !stall && !mapped;
    end
  end

  // Read data, registered alongside ready
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (acc && !pready && !stall && !pwrite) begin
      unique case (paddr)
        cocd_pkg::OFS_CMD:  // Busy then address or identifier [R15]
          prdata <= {24'h00_0000, busy_q, stat_id_q ? PART_ID : ac_q};
        cocd_pkg::OFS_DATA: // Memory contents at the counter [R16]
          prdata <= {24'h00_0000, ac_cg_q ? pat_ram[ac_q[5:0]]
                                          : text_ram[ac_q]};
        cocd_pkg::OFS_CFG0: // Net shift sits above the mode bits
          prdata <= {9'h000, shift_q, disp_q, cur_q, blk_q, inc_q,
                     shift_en_q, dl_q, lines_q, br_q, re_q, sd_q, be_q,
                     rev_q, com_dir_q, seg_dir_q, ac_cg_q};
        cocd_pkg::OFS_CFG1: // Bits 9:8 unused, read as zero
          prdata <= {2'h0, sq_q, split_q, rom_q, osc_q, div_q, gpio_q,
                     2'h0, reg_q};
        cocd_pkg::OFS_CTRL:
          prdata <= {31'h0000_0000, lock_q};
        default:            // Unmapped reads as zero
          prdata <= 32'h0000_0000;
      endcase
    end
  end

  // Interface lock, written by software
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lock_q <= 1'b0;
    end else if (wr && paddr == cocd_pkg::OFS_CTRL) begin
      lock_q <= pwdata[cocd_pkg::CTRL_LOCK];
    end
  end

  // Status read alternates address and identifier; data accesses and writes reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stat_id_q <= 1'b0;
    end else if (rd && hit_cmd) begin
      stat_id_q <= !stat_id_q;                                // [R15]
    end else if (done && (hit_data || pwrite)) begin
      stat_id_q <= 1'b0;
    end
  end

  // Clear sweep: one text location per cycle, busy meanwhile
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy_q <= 1'b0;
      clr_q  <= 7'h00;
    end else if (busy_q) begin
      clr_q  <= clr_q + 7'h01;
      busy_q <= (clr_q != cocd_pkg::CLR_LAST);
    end else if (cmd_ok && !sd_q && wb == cocd_pkg::CMD_CLEAR) begin
      busy_q <= 1'b1;                                         // [R1]
      clr_q  <= 7'h00;
    end
  end

  // Memories: clear sweep and data writes; no reset on storage
  always_ff @(posedge pclk) begin
    if (busy_q) begin
      text_ram[clr_q] <= cocd_pkg::SPACE_CODE;                // [R1]
    end else if (wr && hit_data && pend_q == cocd_pkg::COCD_PEND_NONE
                 && !lock_q) begin
      if (ac_cg_q) begin
        pat_ram[ac_q[5:0]] <= wb;                             // [R16]
      end else begin
        text_ram[ac_q] <= wb;                                 // [R16]
      end
    end
  end

  // Address counter and display shift: commands load, accesses step
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ac_q    <= cocd_pkg::AC_RST;
      ac_cg_q <= 1'b0;
      shift_q <= 7'h00;
    end else if (done && hit_data && pend_q == cocd_pkg::COCD_PEND_NONE
                 && !lock_q) begin
      ac_q <= ac_step(ac_q, inc_q, ac_cg_q);                  // [R3]
      if (shift_en_q && !ac_cg_q) begin
        shift_q <= inc_q ? shift_q + 7'h01 : shift_q - 7'h01; // [R4]
      end
    end else if (cmd_ok && !sd_q) begin
      if (wb == cocd_pkg::CMD_CLEAR) begin
        ac_q    <= cocd_pkg::AC_RST;                          // [R1]
        ac_cg_q <= 1'b0;
      end else if (!re_q && wb[7:1] == 7'h01) begin
        ac_q    <= cocd_pkg::AC_RST;                          // [R2]
        ac_cg_q <= 1'b0;
        shift_q <= 7'h00;
      end else if (!re_q && wb[7:6] == 2'b01) begin
        ac_q    <= {1'b0, wb[5:0]};                           // [R12]
        ac_cg_q <= 1'b1;
      end else if (!re_q && wb[7]) begin
        ac_q    <= wb[6:0];                                   // [R13]
        ac_cg_q <= 1'b0;
      end
    end
  end

  // Basic and extended page commands: entry, on/off, function set, scroll
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      inc_q      <= 1'b1;
      shift_en_q <= 1'b0;
      com_dir_q  <= 1'b1;
      seg_dir_q  <= 1'b1;
      disp_q     <= 1'b0;
      cur_q      <= 1'b0;
      blk_q      <= 1'b0;
      dl_q       <= 1'b1;
      lines_q    <= 1'b1;
      br_q       <= 2'b00;
      be_q       <= 1'b0;
      rev_q      <= 1'b0;
      re_q       <= 1'b0;
      sq_q       <= cocd_pkg::SQ_RST;
    end else if (cmd_ok && !sd_q) begin
      if (wb[7:2] == 6'h01) begin
        if (!re_q) begin
          inc_q      <= wb[1];                                // [R3]
          shift_en_q <= wb[0];                                // [R4]
        end else begin
          com_dir_q  <= wb[1];                                // [R5]
          seg_dir_q  <= wb[0];                                // [R5]
        end
      end else if (!re_q && wb[7:3] == 5'h01) begin
        disp_q <= wb[2];                                      // [R6]
        cur_q  <= wb[1];                                      // [R6]
        blk_q  <= wb[0];                                      // [R6]
      end else if (wb[7:5] == 3'b001) begin
        dl_q <= wb[4];                                        // [R7]
        re_q <= wb[2];                                        // [R10]
        if (!re_q) begin
          lines_q <= wb[3];                                   // [R8]
          br_q    <= wb[1:0];                                 // [R9]
        end else begin
          be_q  <= wb[1];                                     // [R11]
          rev_q <= wb[0];                                     // [R11]
        end
      end else if (re_q && wb[7] && wb[5:0] <= cocd_pkg::SQ_MAX) begin
        sq_q <= wb[5:0];                                      // [R14]
      end
      // Remaining codes fall through with nothing changed [R24]
    end
  end

  // Command set bit: 78/79 on the extended page, in either set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sd_q <= 1'b0;
    end else if (cmd_ok && re_q && wb[7:1] == cocd_pkg::CMD_SD_OFF[7:1]) begin
      sd_q <= wb[0];                                          // [R19]
    end
  end

  // Parameter sequencing for multi-byte commands
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend_q <= cocd_pkg::COCD_PEND_NONE;
    end else if (wr && (hit_cmd || hit_data)) begin
      if (pend_q != cocd_pkg::COCD_PEND_NONE) begin
        pend_q <= cocd_pkg::COCD_PEND_NONE; // Parameter consumed
      end else if (cmd_ok && re_q && !sd_q) begin
        if (wb == cocd_pkg::CMD_FSEL_A) begin
          pend_q <= cocd_pkg::COCD_PEND_REG;                  // [R17]
        end else if (wb == cocd_pkg::CMD_FSEL_B) begin
          pend_q <= cocd_pkg::COCD_PEND_SPLIT;                // [R18]
        end
      end else if (cmd_ok && re_q && sd_q) begin
        // Settings with no effect here are taken and dropped
        unique case (wb)
          cocd_pkg::CMD_CLKDIV: pend_q <= cocd_pkg::COCD_PEND_CLK;
          cocd_pkg::CMD_GPIO:   pend_q <= cocd_pkg::COCD_PEND_GPIO;
          cocd_pkg::CMD_CONTR, cocd_pkg::CMD_PRECH, cocd_pkg::CMD_COMCFG,
          cocd_pkg::CMD_VCOMH, cocd_pkg::CMD_VSL:
                                pend_q <= cocd_pkg::COCD_PEND_SKIP;
          default:              pend_q <= cocd_pkg::COCD_PEND_NONE; // [R24]
        endcase
      end
    end
  end

  // Option registers loaded from parameter bytes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reg_q   <= cocd_pkg::REG_RST;
      split_q <= 2'b00;
      rom_q   <= 2'b00;
      osc_q   <= cocd_pkg::OSC_RST;
      div_q   <= cocd_pkg::DIV_RST;
      gpio_q  <= cocd_pkg::GPIO_RST;
    end else if (wr && (hit_cmd || hit_data)) begin
      unique case (pend_q)
        cocd_pkg::COCD_PEND_REG: begin
          // Only the two defined codes change the regulator
          if (wb == cocd_pkg::REG_OFF || wb == cocd_pkg::REG_RST) begin
            reg_q <= wb;                                      // [R17]
          end
        end
        cocd_pkg::COCD_PEND_SPLIT: begin
          split_q <= wb[1:0];                                 // [R18]
          if (wb[3:2] != 2'b11) begin
            rom_q <= wb[3:2];                                 // [R18]
          end
        end
        cocd_pkg::COCD_PEND_CLK: begin
          osc_q <= wb[7:4];                                   // [R21]
          div_q <= wb[3:0];                                   // [R21]
        end
        cocd_pkg::COCD_PEND_GPIO: gpio_q <= wb[1:0];          // [R22]
        cocd_pkg::COCD_PEND_NONE, cocd_pkg::COCD_PEND_SKIP: begin
        end
      endcase
    end
  end

  // Pin drivers registered from the settings, one cycle behind
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gpio_out     <= 1'b0;
      gpio_oe      <= 1'b1;
      regulator_en <= 1'b1;
    end else begin
      gpio_out     <= (gpio_q == cocd_pkg::GPIO_HIGH);        // [R22]
      gpio_oe      <= gpio_q[1];                              // [R22]
      regulator_en <= (reg_q != cocd_pkg::REG_OFF);           // [R17]
    end
  end

  // Clear leaves the counter at zero and the sweep busy
  property p_clear;
    @(posedge pclk) disable iff (!presetn)
      (cmd_ok && !sd_q && wb == cocd_pkg::CMD_CLEAR)
      |=> (busy_q && ac_q == 7'h00) [*8];
  endproperty
  a_clear: assert property (p_clear) else $error("clear failed"); // [R1]

  // Sweep ends within its length
  property p_clear_len;
    @(posedge pclk) disable iff (!presetn)
      $rose(busy_q) |-> ##[1:128] !busy_q;
  endproperty
  a_clear_len: assert property (p_clear_len) else $error("sweep"); // [R1]

  // Data access steps the counter by one
  property p_step;
    @(posedge pclk) disable iff (!presetn)
      (done && hit_data && pend_q == cocd_pkg::COCD_PEND_NONE && !lock_q
       && !ac_cg_q)
      |=> ac_q == (inc_q ? $past(ac_q) + 7'h01 : $past(ac_q) - 7'h01);
  endproperty
  a_step: assert property (p_step) else $error("counter step"); // [R3]

  // Display control bits follow the command
  property p_onoff;
    @(posedge pclk) disable iff (!presetn)
      (cmd_ok && !sd_q && !re_q && wb[7:3] == 5'h01)
      |=> {disp_q, cur_q, blk_q} == $past(wb[2:0]);
  endproperty
  a_onoff: assert property (p_onoff) else $error("on/off"); // [R6]

  // Function set writes the page bit
  property p_re;
    @(posedge pclk) disable iff (!presetn)
      (cmd_ok && !sd_q && wb[7:5] == 3'b001) |=> re_q == $past(wb[2]);
  endproperty
  a_re: assert property (p_re) else $error("page bit"); // [R10]

  // Scroll quantity never exceeds its legal maximum
  property p_sq;
    @(posedge pclk) disable iff (!presetn) sq_q <= cocd_pkg::SQ_MAX;
  endproperty
  a_sq: assert property (p_sq) else $error("scroll range"); // [R14]

  // Locked interface changes no display state on other commands
  property p_lock;
    @(posedge pclk) disable iff (!presetn)
      (lock_q && wr && hit_cmd && wb != cocd_pkg::CMD_SD_ON)
      |=> $stable({disp_q, ac_q, re_q, sd_q});
  endproperty
  a_lock: assert property (p_lock) else $error("lock"); // [R20]

  // General pin drivers track the mode two cycles after the parameter
  property p_gpio;
    @(posedge pclk) disable iff (!presetn)
      (wr && hit_cmd && pend_q == cocd_pkg::COCD_PEND_GPIO)
      |=> ##1 gpio_oe == $past(wb[1], 2)
              && gpio_out == ($past(wb[1:0], 2) == 2'b11);
  endproperty
  a_gpio: assert property (p_gpio) else $error("gpio pin"); // [R22]

  // Status reads carry the busy flag
  property p_status;
    @(posedge pclk) disable iff (!presetn)
      (acc && !pready && !pwrite && hit_cmd) |=> prdata[7] == $past(busy_q);
  endproperty
  a_status: assert property (p_status) else $error("status"); // [R15]

endmodule

// >>> cocd_host.sv
/*
  APB master model standing in for the host controller.
  Assumes the bench calls xfer from one process; pclk runs freely.
*/
`timescale 1ns/1ns
module cocd_host (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr
);
  // Idle bus from time zero
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0000_0000;
  end

  // One transfer; address picks command or data port
  task automatic xfer(input logic wr, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Hold until pready is seen high at an edge; clear sweep may stall.
    // Only the bench watchdog ends a wait that never completes.
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// >>> cocd_pkg.sv
/*
  Constants for the character display command decoder: register offsets,
  field positions, reset values and memory sizes.
  Assumes a 32-bit APB bus with byte addresses and one word per register.
*/
package cocd_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CMD    = 8'h00; // W command, R status
  localparam logic [7:0] OFS_DATA   = 8'h04; // W/R display memory data
  localparam logic [7:0] OFS_CFG0   = 8'h08; // R display and mode state
  localparam logic [7:0] OFS_CFG1   = 8'h0C; // R extended option state
  localparam logic [7:0] OFS_CTRL   = 8'h10; // R/W interface lock
  // Control field
  localparam int         CTRL_LOCK  = 0;     // Lock bit position
  // Command codes and masks
  localparam logic [7:0] CMD_CLEAR  = 8'h01;
  localparam logic [7:0] CMD_FSEL_A = 8'h71;
  localparam logic [7:0] CMD_FSEL_B = 8'h72;
  localparam logic [7:0] CMD_SD_OFF = 8'h78;
  localparam logic [7:0] CMD_SD_ON  = 8'h79;
  localparam logic [7:0] CMD_CONTR  = 8'h81;
  localparam logic [7:0] CMD_CLKDIV = 8'hD5;
  localparam logic [7:0] CMD_PRECH  = 8'hD9;
  localparam logic [7:0] CMD_COMCFG = 8'hDA;
  localparam logic [7:0] CMD_VCOMH  = 8'hDB;
  localparam logic [7:0] CMD_GPIO   = 8'hDC;
  localparam logic [7:0] CMD_VSL    = 8'hF2;
  // Reset values
  localparam logic [6:0] AC_RST     = 7'h00;
  localparam logic [5:0] SQ_RST     = 6'h00;
  localparam logic [5:0] SQ_MAX     = 6'h30; // Largest legal scroll value
  localparam logic [7:0] REG_RST    = 8'h5C; // Core regulator enabled
  localparam logic [7:0] REG_OFF    = 8'h00; // Core regulator disabled
  localparam logic [3:0] OSC_RST    = 4'h4;
  localparam logic [3:0] DIV_RST    = 4'h0;
  localparam logic [1:0] GPIO_RST   = 2'h2;  // Drive low
  localparam logic [1:0] GPIO_HIGH  = 2'h3;
  localparam logic [1:0] GPIO_LOW   = 2'h2;
  localparam logic [7:0] SPACE_CODE = 8'h20;
  // Memory sizes and last clear sweep index
  localparam int         TEXT_WORDS = 128;
  localparam int         PAT_WORDS  = 64;
  localparam logic [6:0] CLR_LAST   = 7'h7F;
  // Parameter byte expected after a multi-byte command
  typedef enum logic [2:0] {
    COCD_PEND_NONE, COCD_PEND_REG, COCD_PEND_SPLIT,
    COCD_PEND_CLK, COCD_PEND_GPIO, COCD_PEND_SKIP
  } cocd_pend_t;
endpackage
